// ### common/acr_pkg.sv
// constants of the mmio reset and capability register bank
package acr_pkg;
   localparam int AW = 16;
   localparam int DW = 64;
   localparam int NGRP = 2;
   localparam int NWQ = 2;
   // byte offsets of registers and tables
   localparam logic [15:0] OFF_VERSION  = 16'h0000;
   localparam logic [15:0] OFF_GENERAL_CAPABILITIES   = 16'h0010;
   localparam logic [15:0] OFF_TBLOFF   = 16'h0060;
   localparam logic [15:0] OFF_GENCFG   = 16'h0080;
   localparam logic [15:0] OFF_GENCTRL  = 16'h0088;
   localparam logic [15:0] OFF_GENSTS   = 16'h0090;
   localparam logic [15:0] OFF_INTCAUSE = 16'h0098;
   localparam logic [15:0] OFF_CMD      = 16'h00a0;
   localparam logic [15:0] OFF_CMDSTS   = 16'h00a8;
   localparam logic [15:0] OFF_SWERR    = 16'h00c0;
   localparam logic [15:0] OFF_PERM     = 16'h0400;
   localparam logic [15:0] OFF_GRPCFG   = 16'h0600;
   localparam logic [15:0] OFF_WQCFG    = 16'h0800;
   localparam logic [15:0] OFF_PERF     = 16'h2000;
   localparam logic [15:0] OFF_MSIX     = 16'h4000;
   localparam logic [15:0] OFF_PBA      = 16'h5000;
   localparam logic [15:0] OFF_IMS      = 16'h8000;
   localparam logic [15:0] GRP_STRIDE   = 16'h0040;
   localparam logic [15:0] WQ_STRIDE    = 16'h0020;
   localparam logic [15:0] QW           = 16'h0008;
   // identity and capability values (arbitrary)
   localparam logic [7:0] VER_MAJOR = 8'h01;
   localparam logic [7:0] VER_MINOR = 8'h00;
   localparam logic [7:0] CAP_MAXDESC = 8'h20;
   localparam logic CAP_CFGSUP = 1'b1;
   localparam logic [5:0] CAP_IMSSZ = 6'h01;
   localparam logic [3:0] CAP_BATCH = 4'h5;
   localparam logic [20:0] CAP_LOW = 21'h000000;
   localparam int CFGSUP_BIT = 31;
   localparam logic [63:0] VERSION_VAL = {48'h0, VER_MAJOR, VER_MINOR};
   localparam logic [63:0] GENERAL_CAPABILITIES_VAL =
      {24'h0, CAP_MAXDESC, CAP_CFGSUP, CAP_IMSSZ, CAP_BATCH, CAP_LOW};
   // table offsets in units of 256 bytes: ims, perf, wq, grp, perm
   localparam logic [63:0] TBLOFF_VAL = {24'h0, OFF_IMS[15:8], OFF_PERF[15:8],
      OFF_WQCFG[15:8], OFF_GRPCFG[15:8], OFF_PERM[15:8]};
   // reset values and field positions
   localparam logic [7:0] TOTAL_BW_TOKENS = 8'h10;
   localparam logic [63:0] GRP_RST_VAL = {56'h0, TOTAL_BW_TOKENS};
   localparam logic [63:0] GRP_FIXED = 64'h0000_0001_0000_0010;
   localparam logic [63:0] WQ_FIXED = 64'h0000_0000_0000_0010;
   localparam logic [63:0] WQ_RO_MASK = 64'h0000_0000_0000_ffff;
   localparam logic [15:0] PERF_FILT_RST = 16'hffff;
   localparam logic [63:0] IMS_ADDR_RST = 64'h0000_0000_fee0_0000;
   localparam int MASK_BIT = 32;
   localparam int PASIDEN_BIT = 33;
   localparam int IGN_BIT = 34;
   localparam int PEND_BIT = 35;
   localparam int PASID_LSB = 36;
   localparam int ACTIVE_BIT = 31;
   localparam int SWERR_CODE_LSB = 8;
endpackage

// ### hdl/acr_regs.sv
// mmio register bank: capabilities, configuration and per-reset values
`timescale 1ns/10ps
// Contract
// - capability and table-offset registers are constant
// - config, control, status, cause, tables reset zero
// - group entry resets tokens to total tokens
// - perfmon filters reset ffff, others zero
// - msix and ims entries reset masked, ims address fixed
// - general and group config locked unless disabled
// - without config support, fixed values at reset
// - capability bit 31 reports configurability
// - tables live at offsets the offset register reports
// - version register: major 15:8, minor 7:0
// - capability 39:32 gives descriptors in progress
// - capability 30:25 gives storage size over 256
// - capability 24:21 gives log2 max batch
module acr_regs (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        flr_req,
   input  wire logic        sw_reset,
   input  wire logic        dev_enabled,
   input  wire logic [3:0]  int_event,
   input  wire logic        cmd_done,
   input  wire logic [7:0]  cmd_result,
   input  wire logic        sw_err_valid,
   input  wire logic [7:0]  sw_err_code,
   input  wire logic        perf_event,
   input  wire logic [15:0] mmio_addr,
   input  wire logic        mmio_rd,
   input  wire logic        mmio_wr,
   input  wire logic [63:0] mmio_wdata,
   output logic      [63:0] mmio_rdata,
   output logic             mmio_rvalid,
   output logic      [63:0] gen_config,
   output logic      [63:0] gen_control,
   output logic      [31:0] command
);
   logic [63:0] gen_cfg_r;
   logic [63:0] gen_ctrl_r;
   logic        gen_sts_r;
   logic [3:0]  int_cause_r;
   logic [31:0] cmd_r;
   logic [31:0] cmd_sts_r;
   logic [15:0] sw_err_r;
   logic [63:0] perm_r;
   logic [63:0] grp_r [acr_pkg::NGRP];
   logic [63:0] wq_r [acr_pkg::NWQ];
   logic [15:0] perf_filt_r;
   logic [63:0] perf_cnt_r;
   logic [63:0] msix_addr_r;
   logic [31:0] msix_data_r;
   logic        msix_mask_r;
   logic        pba_r;
   logic [63:0] ims_addr_r;
   logic [63:0] ims_ctl_r;
   logic [63:0] rd_nxt;
   logic        any_rst;
   logic        cfg_sup;
   logic [63:0] grp_init;
   logic [63:0] wq_init;
   // qword address match
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a[15:3] == off[15:3]);
   endfunction
   // every reset source that is not the async one
   assign any_rst = flr_req | sw_reset;
   assign cfg_sup = acr_pkg::GENERAL_CAPABILITIES_VAL[acr_pkg::CFGSUP_BIT];
   // group and wq start-up contents depend on config support
   assign grp_init = cfg_sup ? acr_pkg::GRP_RST_VAL : acr_pkg::GRP_FIXED;
   assign wq_init = cfg_sup ? 64'h0 : acr_pkg::WQ_FIXED;
   // general configuration, writable only while disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gen_cfg_r <= 64'h0;
      end else if (any_rst) begin
         gen_cfg_r <= 64'h0;
      end else if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_GENCFG) && !dev_enabled) begin
         gen_cfg_r <= mmio_wdata;
      end
   end
   // general control and status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gen_ctrl_r <= 64'h0;
         gen_sts_r <= 1'b0;
      end else if (any_rst) begin
         gen_ctrl_r <= 64'h0;
         gen_sts_r <= 1'b0;
      end else begin
         gen_sts_r <= dev_enabled;
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_GENCTRL)) begin
            gen_ctrl_r <= mmio_wdata;
         end
      end
   end
   // interrupt cause: sticky, write one to clear, a new event wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_cause_r <= 4'h0;
      end else if (any_rst) begin
         int_cause_r <= 4'h0;
      end else if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_INTCAUSE)) begin
         int_cause_r <= (int_cause_r & ~mmio_wdata[3:0]) | int_event;
      end else begin
         int_cause_r <= int_cause_r | int_event;
      end
   end
   // command and its status: cleared by hard resets, kept on software reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_r <= 32'h0;
         cmd_sts_r <= 32'h0;
      end else if (flr_req) begin
         cmd_r <= 32'h0;
         cmd_sts_r <= 32'h0;
      end else if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_CMD) && !sw_reset) begin
         cmd_r <= mmio_wdata[31:0];
         cmd_sts_r <= 32'h0;
         cmd_sts_r[acr_pkg::ACTIVE_BIT] <= 1'b1;
      end else if (cmd_done && !sw_reset) begin
         cmd_sts_r <= {24'h0, cmd_result}; // completion drops active
      end
   end
   // software error: valid in bit 0, write one to clear, capture only while bit 0 is clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_err_r <= 16'h0;
      end else if (flr_req) begin
         sw_err_r <= 16'h0;
      end else if (sw_reset) begin
         sw_err_r <= sw_err_r;
      end else if (sw_err_valid && !sw_err_r[0]) begin
         sw_err_r <= {sw_err_code, 8'h01};
      end else if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_SWERR) && mmio_wdata[0]) begin
         sw_err_r <= 16'h0;
      end
   end
   // permissions table entry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         perm_r <= 64'h0;
      end else if (any_rst) begin
         perm_r <= 64'h0;
      end else if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_PERM)) begin
         perm_r <= mmio_wdata;
      end
   end
   // group configuration entries
   for (genvar g = 0; g < acr_pkg::NGRP; g++) begin : g_grp
      localparam logic [15:0] GA = acr_pkg::OFF_GRPCFG + 16'(g) * acr_pkg::GRP_STRIDE;
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            grp_r[g] <= acr_pkg::CAP_CFGSUP ? acr_pkg::GRP_RST_VAL : acr_pkg::GRP_FIXED;
         end else if (any_rst) begin
            grp_r[g] <= grp_init;
         end else if (mmio_wr && hit(mmio_addr, GA) && !dev_enabled && cfg_sup) begin
            grp_r[g] <= mmio_wdata;
         end
      end
   end
   // work-queue configuration entries; fixed fields hold without support
   for (genvar w = 0; w < acr_pkg::NWQ; w++) begin : g_wq
      localparam logic [15:0] WA = acr_pkg::OFF_WQCFG + 16'(w) * acr_pkg::WQ_STRIDE;
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            wq_r[w] <= acr_pkg::CAP_CFGSUP ? 64'h0 : acr_pkg::WQ_FIXED;
         end else if (any_rst) begin
            wq_r[w] <= wq_init;
         end else if (mmio_wr && hit(mmio_addr, WA) && !dev_enabled) begin
            if (cfg_sup) begin
               wq_r[w] <= mmio_wdata;
            end else begin
               wq_r[w] <= (mmio_wdata & ~acr_pkg::WQ_RO_MASK)
                        | (wq_r[w] & acr_pkg::WQ_RO_MASK);
            end
         end
      end
   end
   // performance monitor filter and event counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         perf_filt_r <= acr_pkg::PERF_FILT_RST;
         perf_cnt_r <= 64'h0;
      end else if (any_rst) begin
         perf_filt_r <= acr_pkg::PERF_FILT_RST;
         perf_cnt_r <= 64'h0;
      end else begin
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_PERF)) begin
            perf_filt_r <= mmio_wdata[15:0];
         end
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_PERF + acr_pkg::QW)) begin
            perf_cnt_r <= mmio_wdata;
         end else if (perf_event) begin
            perf_cnt_r <= perf_cnt_r + 64'h1;
         end
      end
   end
   // msix entry and its pending bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msix_addr_r <= 64'h0;
         msix_data_r <= 32'h0;
         msix_mask_r <= 1'b1;
         pba_r <= 1'b0;
      end else if (any_rst) begin
         msix_addr_r <= 64'h0;
         msix_data_r <= 32'h0;
         msix_mask_r <= 1'b1;
         pba_r <= 1'b0;
      end else begin
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_MSIX)) begin
            msix_addr_r <= mmio_wdata;
         end
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_MSIX + acr_pkg::QW)) begin
            msix_data_r <= mmio_wdata[31:0];
            msix_mask_r <= mmio_wdata[acr_pkg::MASK_BIT];
         end
         // held while masked, released once unmasked
         if (|int_event && msix_mask_r) begin
            pba_r <= 1'b1;
         end else if (!msix_mask_r) begin
            pba_r <= 1'b0;
         end
      end
   end
   // interrupt message storage entry; pending is hardware owned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ims_addr_r <= acr_pkg::IMS_ADDR_RST;
         ims_ctl_r <= 64'h0;
         ims_ctl_r[acr_pkg::MASK_BIT] <= 1'b1;
      end else if (any_rst) begin
         ims_addr_r <= acr_pkg::IMS_ADDR_RST;
         ims_ctl_r <= 64'h0;
         ims_ctl_r[acr_pkg::MASK_BIT] <= 1'b1;
      end else begin
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_IMS)) begin
            ims_addr_r <= mmio_wdata;
         end
         if (mmio_wr && hit(mmio_addr, acr_pkg::OFF_IMS + acr_pkg::QW)) begin
            ims_ctl_r[34:0] <= mmio_wdata[34:0];
            ims_ctl_r[55:36] <= mmio_wdata[55:36];
         end
         if (|int_event && ims_ctl_r[acr_pkg::MASK_BIT]) begin
            ims_ctl_r[acr_pkg::PEND_BIT] <= 1'b1;
         end else if (!ims_ctl_r[acr_pkg::MASK_BIT]) begin
            ims_ctl_r[acr_pkg::PEND_BIT] <= 1'b0;
         end
      end
   end
   // read decode; unmapped words read zero
   always_comb begin
      rd_nxt = 64'h0;
      if (hit(mmio_addr, acr_pkg::OFF_VERSION)) rd_nxt = acr_pkg::VERSION_VAL;
      if (hit(mmio_addr, acr_pkg::OFF_GENERAL_CAPABILITIES)) rd_nxt = acr_pkg::GENERAL_CAPABILITIES_VAL;
      if (hit(mmio_addr, acr_pkg::OFF_TBLOFF)) rd_nxt = acr_pkg::TBLOFF_VAL;
      if (hit(mmio_addr, acr_pkg::OFF_GENCFG)) rd_nxt = gen_cfg_r;
      if (hit(mmio_addr, acr_pkg::OFF_GENCTRL)) rd_nxt = gen_ctrl_r;
      if (hit(mmio_addr, acr_pkg::OFF_GENSTS)) rd_nxt = {63'h0, gen_sts_r};
      if (hit(mmio_addr, acr_pkg::OFF_INTCAUSE)) rd_nxt = {60'h0, int_cause_r};
      if (hit(mmio_addr, acr_pkg::OFF_CMD)) rd_nxt = {32'h0, cmd_r};
      if (hit(mmio_addr, acr_pkg::OFF_CMDSTS)) rd_nxt = {32'h0, cmd_sts_r};
      if (hit(mmio_addr, acr_pkg::OFF_SWERR)) rd_nxt = {48'h0, sw_err_r};
      if (hit(mmio_addr, acr_pkg::OFF_PERM)) rd_nxt = perm_r;
      for (int g = 0; g < acr_pkg::NGRP; g++) begin
         if (hit(mmio_addr, acr_pkg::OFF_GRPCFG + 16'(g) * acr_pkg::GRP_STRIDE)) begin
            rd_nxt = grp_r[g];
         end
      end
      for (int w = 0; w < acr_pkg::NWQ; w++) begin
         if (hit(mmio_addr, acr_pkg::OFF_WQCFG + 16'(w) * acr_pkg::WQ_STRIDE)) begin
            rd_nxt = wq_r[w];
         end
      end
      if (hit(mmio_addr, acr_pkg::OFF_PERF)) rd_nxt = {48'h0, perf_filt_r};
      if (hit(mmio_addr, acr_pkg::OFF_PERF + acr_pkg::QW)) rd_nxt = perf_cnt_r;
      if (hit(mmio_addr, acr_pkg::OFF_MSIX)) rd_nxt = msix_addr_r;
      if (hit(mmio_addr, acr_pkg::OFF_MSIX + acr_pkg::QW)) begin
         rd_nxt = {31'h0, msix_mask_r, msix_data_r};
      end
      if (hit(mmio_addr, acr_pkg::OFF_PBA)) rd_nxt = {63'h0, pba_r};
      if (hit(mmio_addr, acr_pkg::OFF_IMS)) rd_nxt = ims_addr_r;
      if (hit(mmio_addr, acr_pkg::OFF_IMS + acr_pkg::QW)) rd_nxt = ims_ctl_r;
   end
   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mmio_rdata <= 64'h0;
         mmio_rvalid <= 1'b0;
      end else begin
         mmio_rvalid <= mmio_rd;
         mmio_rdata <= mmio_rd ? rd_nxt : 64'h0;
      end
   end
   assign gen_config = gen_cfg_r;
   assign gen_control = gen_ctrl_r;
   assign command = cmd_r;
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_version_read: assert property (mmio_rd && hit(mmio_addr, acr_pkg::OFF_VERSION)
      |=> mmio_rvalid && mmio_rdata[15:8] == acr_pkg::VER_MAJOR
          && mmio_rdata[7:0] == acr_pkg::VER_MINOR && mmio_rdata[31:16] == 16'h0)
      else $error("version read wrong");
   a_general_capabilities_read: assert property (mmio_rd && hit(mmio_addr, acr_pkg::OFF_GENERAL_CAPABILITIES)
      |=> mmio_rdata[39:32] == acr_pkg::CAP_MAXDESC && mmio_rdata[31] == cfg_sup
          && mmio_rdata[30:25] == acr_pkg::CAP_IMSSZ
          && mmio_rdata[24:21] == acr_pkg::CAP_BATCH)
      else $error("capability read wrong");
   a_tbloff_read: assert property (mmio_rd && hit(mmio_addr, acr_pkg::OFF_TBLOFF)
      |=> mmio_rdata[15:8] == acr_pkg::OFF_GRPCFG[15:8])
      else $error("table offset read wrong");
   a_cfg_lock: assert property (dev_enabled && !any_rst
      |=> $stable(gen_cfg_r) && $stable(grp_r[0]))
      else $error("config changed while enabled");
   a_reset_zero: assert property (any_rst
      |=> gen_cfg_r == 64'h0 && gen_ctrl_r == 64'h0 && perm_r == 64'h0)
      else $error("register not zero after reset");
   a_grp_tokens: assert property (any_rst |=> grp_r[0] == grp_init)
      else $error("group tokens wrong after reset");
   a_perf_reset: assert property (any_rst
      |=> perf_filt_r == 16'hffff && perf_cnt_r == 64'h0)
      else $error("perfmon reset wrong");
   a_intr_reset: assert property (any_rst |=> msix_mask_r && ims_ctl_r[acr_pkg::MASK_BIT]
      && ims_addr_r == 64'h0000_0000_fee0_0000 && msix_addr_r == 64'h0)
      else $error("interrupt entry reset wrong");
   a_cmd_keep: assert property (sw_reset && !flr_req
      |=> cmd_r == $past(cmd_r) && sw_err_r == $past(sw_err_r))
      else $error("command lost on software reset");
   a_cmd_clear: assert property (flr_req |=> cmd_r == 32'h0 && cmd_sts_r == 32'h0)
      else $error("command not cleared");
   c_locked_write: cover property (dev_enabled && mmio_wr && hit(mmio_addr, acr_pkg::OFF_GENCFG));
   c_sw_keep: cover property (cmd_r != 32'h0 ##1 sw_reset);
   c_event_clear: cover property (int_event != 4'h0 && mmio_wr
      && hit(mmio_addr, acr_pkg::OFF_INTCAUSE));
endmodule

// ### test/acr_tb.sv
// self-checking bench for the mmio reset and capability register bank
`timescale 1ns/10ps
`define CHK(g, e) cmp(64'(g), 64'(e))
module testbench;
   logic        clk;
   logic        rst;
   logic        flr_req;
   logic        sw_reset;
   logic        dev_enabled;
   logic [3:0]  int_event;
   logic        cmd_done;
   logic [7:0]  cmd_result;
   logic        sw_err_valid;
   logic [7:0]  sw_err_code;
   logic        perf_event;
   logic [15:0] mmio_addr;
   logic        mmio_rd;
   logic        mmio_wr;
   logic [63:0] mmio_wdata;
   logic [63:0] mmio_rdata;
   logic        mmio_rvalid;
   logic [63:0] gen_config;
   logic [63:0] gen_control;
   logic [31:0] command;
   int          mismatches;
   int          checks;

   // registers that every reset kind clears to zero
   localparam logic [15:0] ZR [10] = '{acr_pkg::OFF_GENCFG, acr_pkg::OFF_GENCTRL,
      acr_pkg::OFF_GENSTS, acr_pkg::OFF_INTCAUSE, acr_pkg::OFF_PERM, acr_pkg::OFF_WQCFG,
      acr_pkg::OFF_WQCFG + 16'h0020, acr_pkg::OFF_PERF + 16'h0008, acr_pkg::OFF_MSIX,
      acr_pkg::OFF_PBA};
   localparam logic [63:0] TOK = {56'h0, acr_pkg::TOTAL_BW_TOKENS};

   acr_regs u_dut (.clk(clk), .rst(rst), .flr_req(flr_req), .sw_reset(sw_reset),
      .dev_enabled(dev_enabled), .int_event(int_event), .cmd_done(cmd_done),
      .cmd_result(cmd_result), .sw_err_valid(sw_err_valid), .sw_err_code(sw_err_code),
      .perf_event(perf_event), .mmio_addr(mmio_addr), .mmio_rd(mmio_rd),
      .mmio_wr(mmio_wr), .mmio_wdata(mmio_wdata), .mmio_rdata(mmio_rdata),
      .mmio_rvalid(mmio_rvalid), .gen_config(gen_config), .gen_control(gen_control),
      .command(command));

   // 20 mhz clock
   always #25 clk = ~clk;

   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one read: strobe for one edge, answer one edge later
   task automatic rd(input logic [15:0] a, output logic [63:0] d);
      int n;
      @(posedge clk);
      mmio_addr <= a;
      mmio_rd <= 1'b1;
      @(posedge clk);
      mmio_rd <= 1'b0;
      #1;
      n = 0;
      while (mmio_rvalid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (mmio_rvalid !== 1'b1) begin
         mismatches++;
         summarize();
      end
      d = mmio_rdata;
   endtask

   task automatic wr(input logic [15:0] a, input logic [63:0] v);
      @(posedge clk);
      mmio_addr <= a;
      mmio_wdata <= v;
      mmio_wr <= 1'b1;
      @(posedge clk);
      mmio_wr <= 1'b0;
   endtask

   // one-cycle pulse on a sideband input, picked by k
   task automatic evt(input int k);
      @(posedge clk);
      case (k)
         0: sw_reset <= 1'b1;
         1: flr_req <= 1'b1;
         2: cmd_done <= 1'b1;
         3: sw_err_valid <= 1'b1;
         4: perf_event <= 1'b1;
         default: int_event <= 4'h1;
      endcase
      @(posedge clk);
      sw_reset <= 1'b0;
      flr_req <= 1'b0;
      cmd_done <= 1'b0;
      sw_err_valid <= 1'b0;
      perf_event <= 1'b0;
      int_event <= 4'h0;
   endtask

   // constant registers, their fields, and tables found through the offsets
   task automatic t_ident();
      logic [63:0] d;
      logic [63:0] t;
      rd(acr_pkg::OFF_GENERAL_CAPABILITIES, d);
      `CHK(d[39:32], acr_pkg::CAP_MAXDESC);
      `CHK(d[31], acr_pkg::CAP_CFGSUP);
      `CHK(d[30:25], acr_pkg::CAP_IMSSZ);
      `CHK(d[24:21], acr_pkg::CAP_BATCH);
      `CHK(d[63:40], 24'h0);
      wr(acr_pkg::OFF_VERSION, '1);
      wr(acr_pkg::OFF_GENERAL_CAPABILITIES, 64'h0);
      wr(acr_pkg::OFF_TBLOFF, '1);
      rd(acr_pkg::OFF_VERSION, d);
      `CHK(d[15:8], acr_pkg::VER_MAJOR);
      `CHK(d[7:0], acr_pkg::VER_MINOR);
      `CHK(d[31:16], 16'h0);
      rd(acr_pkg::OFF_GENERAL_CAPABILITIES, d);
      `CHK(d, {24'h0, acr_pkg::CAP_MAXDESC, acr_pkg::CAP_CFGSUP, acr_pkg::CAP_IMSSZ,
         acr_pkg::CAP_BATCH, acr_pkg::CAP_LOW});
      rd(acr_pkg::OFF_TBLOFF, t);
      `CHK(t, {24'h0, acr_pkg::OFF_IMS[15:8], acr_pkg::OFF_PERF[15:8],
         acr_pkg::OFF_WQCFG[15:8], acr_pkg::OFF_GRPCFG[15:8], acr_pkg::OFF_PERM[15:8]});
      rd({t[15:8], 8'h00}, d);
      `CHK(d, TOK);
      rd({t[31:24], 8'h00}, d);
      `CHK(d, 64'hffff);
      rd({t[39:32], 8'h00}, d);
      `CHK(d, 64'h0000_0000_fee0_0000);
      rd(16'h7ff8, d);
      `CHK(d, 64'h0);
   endtask

   // configuration locked while the device is enabled, writable otherwise
   task automatic t_lock();
      logic [63:0] d;
      @(posedge clk);
      dev_enabled <= 1'b1;
      wr(acr_pkg::OFF_GENCFG, 64'ha5);
      wr(acr_pkg::OFF_GRPCFG, 64'h33);
      rd(acr_pkg::OFF_GENCFG, d);
      `CHK(d, 64'h0);
      `CHK(gen_config, 64'h0);
      rd(acr_pkg::OFF_GRPCFG, d);
      `CHK(d, TOK);
      @(posedge clk);
      dev_enabled <= 1'b0;
      wr(acr_pkg::OFF_GENCFG, 64'ha5);
      wr(acr_pkg::OFF_GRPCFG, 64'h33);
      rd(acr_pkg::OFF_GENCFG, d);
      `CHK(d, 64'ha5);
      `CHK(gen_config, 64'ha5);
      rd(acr_pkg::OFF_GRPCFG, d);
      `CHK(d, 64'h33);
   endtask

   // leave non-reset state in every register class except general status and the msix address
   task automatic dirty();
      logic [63:0] d;
      wr(acr_pkg::OFF_GENCFG, 64'h5a);
      wr(acr_pkg::OFF_GENCTRL, 64'h1);
      wr(acr_pkg::OFF_GRPCFG + acr_pkg::GRP_STRIDE, 64'h7);
      wr(acr_pkg::OFF_WQCFG, 64'h11);
      wr(acr_pkg::OFF_WQCFG + acr_pkg::WQ_STRIDE, 64'h22);
      wr(acr_pkg::OFF_PERM, 64'h3);
      wr(acr_pkg::OFF_PERF, 64'h1234);
      // msix stays masked so the next event leaves its pending bit set
      wr(acr_pkg::OFF_MSIX + acr_pkg::QW, 64'h1_0000_0009);
      wr(acr_pkg::OFF_IMS + acr_pkg::QW, 64'h9);
      wr(acr_pkg::OFF_IMS, 64'h40);
      evt(4);
      evt(5);
      wr(acr_pkg::OFF_CMD, 64'h42);
      cmd_result <= 8'h3c;
      evt(2);
      sw_err_code <= 8'h5a;
      evt(3);
      rd(acr_pkg::OFF_INTCAUSE, d);
      `CHK(d[0], 1'b1);
      rd(acr_pkg::OFF_PBA, d);
      `CHK(d, 64'h1);
   endtask

   // values after a reset; command group kept only across software reset
   task automatic chk_reset(input bit keep);
      logic [63:0] d;
      foreach (ZR[i]) begin
         rd(ZR[i], d);
         `CHK(d, 64'h0);
      end
      `CHK(gen_config, 64'h0);
      `CHK(gen_control, 64'h0);
      rd(acr_pkg::OFF_GRPCFG + acr_pkg::GRP_STRIDE, d);
      `CHK(d, TOK);
      rd(acr_pkg::OFF_PERF, d);
      `CHK(d, 64'hffff);
      rd(acr_pkg::OFF_MSIX + acr_pkg::QW, d);
      `CHK(d, 64'h1_0000_0000);
      rd(acr_pkg::OFF_IMS + acr_pkg::QW, d);
      `CHK(d, 64'h1_0000_0000);
      rd(acr_pkg::OFF_IMS, d);
      `CHK(d, 64'h0000_0000_fee0_0000);
      rd(acr_pkg::OFF_CMD, d);
      `CHK(d, keep ? 64'h42 : 64'h0);
      `CHK(command, keep ? 32'h42 : 32'h0);
      rd(acr_pkg::OFF_CMDSTS, d);
      `CHK(d, keep ? 64'h3c : 64'h0);
      rd(acr_pkg::OFF_SWERR, d);
      `CHK(d, keep ? 64'h5a01 : 64'h0);
   endtask

   // software, function-level and a second power-on reset in turn
   task automatic t_resets();
      dirty();
      evt(0);
      chk_reset(1'b1);
      dirty();
      evt(1);
      chk_reset(1'b0);
      dirty();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk_reset(1'b0);
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {flr_req, sw_reset, dev_enabled, cmd_done, sw_err_valid, perf_event} = '0;
      int_event = 4'h0;
      cmd_result = 8'h0;
      sw_err_code = 8'h0;
      mmio_addr = 16'h0;
      {mmio_rd, mmio_wr} = 2'b00;
      mmio_wdata = 64'h0;
      mismatches = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_ident();
      t_lock();
      t_resets();
      summarize();
   end
endmodule
